// ===== hdl/vrp_pkg.sv
// shared constants for the vector register partition map
package vrp_pkg;
    // architectural register file shape
    localparam int          ARCH_REGS   = 32;
    localparam int          IDX_W       = 5;
    localparam int          VWIDTH      = 128;  // vector_width_bits
    // control register word
    localparam int          CTL_W       = 32;
    localparam logic [31:0] MASK_RESET  = 32'h0;
    localparam int          ENABLE_BIT  = 0;
    // control register selects
    localparam int          CSEL_W       = 3;
    localparam logic [2:0]  CSEL_ENABLE  = 3'h1;
    localparam logic [2:0]  CSEL_ACCESS  = 3'h2;
    localparam logic [2:0]  CSEL_SAVE    = 3'h3;
    localparam logic [2:0]  CSEL_MODIFY  = 3'h4;
    localparam logic [2:0]  CSEL_REQUEST = 3'h5;
    localparam logic [2:0]  CSEL_MAP     = 3'h6;
    localparam logic [2:0]  CSEL_UNMAP   = 3'h7;
endpackage : vrp_pkg

// ===== hdl/vrp_phys_pool.sv
// shared pool of physical vector registers, one write and one read port
module vrp_phys_pool
    import vrp_pkg::*;
#(
    parameter int DEPTH = 64,
    parameter int WIDTH = VWIDTH,
    localparam int AW   = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             rstn_in,
    // write port
    input  wire logic             wr_en_in,
    input  wire logic [AW-1:0]    wr_idx_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    // read port, data registered
    input  wire logic             rd_en_in,
    input  wire logic [AW-1:0]    rd_idx_in,
    output logic      [WIDTH-1:0] rd_data_out
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rdata;
    } vrp_pool_type;

    vrp_pool_type st_reg;
    vrp_pool_type st_next;

    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad
            $error("vrp_phys_pool: DEPTH must be 2 or more");
        end
    endgenerate

    // read sees the old word when both ports hit one entry
    always_comb begin
        st_next = st_reg;
        if (rd_en_in) begin
            st_next.rdata = st_reg.mem[rd_idx_in];
        end
        if (wr_en_in) begin
            st_next.mem[wr_idx_in] = wr_data_in;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data_out = st_reg.rdata;
endmodule : vrp_phys_pool

// ===== hdl/vrp_partition_map.sv
// per-context vector register partitioning over a shared physical pool
module vrp_partition_map
    import vrp_pkg::*;
#(
    parameter int NUM_CTX  = 4,
    parameter int NUM_PHYS = 64,
    localparam int CW      = (NUM_CTX > 1) ? $clog2(NUM_CTX) : 1,
    localparam int PW      = (NUM_PHYS > 1) ? $clog2(NUM_PHYS) : 1
) (
    // clock and reset
    input  wire logic                 clock_in,
    input  wire logic                 rstn_in,
    // control register access
    input  wire logic                 ctl_write_in,
    input  wire logic                 ctl_read_in,
    input  wire logic                 ctl_priv_in,
    input  wire logic [CW-1:0]        ctl_ctx_in,
    input  wire logic [CSEL_W-1:0]    ctl_sel_in,
    input  wire logic [CTL_W-1:0]     ctl_wdata_in,
    output logic      [CTL_W-1:0]     ctl_rdata_out,
    output logic                      ctl_cop0_unusable_out,
    // instruction check and register access
    input  wire logic                 ins_valid_in,
    input  wire logic [CW-1:0]        ins_ctx_in,
    input  wire logic [ARCH_REGS-1:0] ins_use_mask_in,
    input  wire logic                 ins_write_in,
    input  wire logic [IDX_W-1:0]     ins_dst_in,
    input  wire logic [VWIDTH-1:0]    ins_wdata_in,
    input  wire logic [IDX_W-1:0]     ins_src_in,
    output logic                      ins_done_out,
    output logic                      ins_fault_out,
    output logic      [VWIDTH-1:0]    ins_rdata_out,
    // unit enable per context
    output logic      [NUM_CTX-1:0]   vector_unit_enable_out
);
    typedef struct packed {
        logic [NUM_PHYS-1:0]                used;
        logic [NUM_PHYS-1:0][CW-1:0]        owner;
        logic [NUM_PHYS-1:0][IDX_W-1:0]     arch;
        logic [NUM_CTX-1:0][ARCH_REGS-1:0]  access;
        logic [NUM_CTX-1:0][ARCH_REGS-1:0]  save;
        logic [NUM_CTX-1:0][ARCH_REGS-1:0]  modify;
        logic [NUM_CTX-1:0][ARCH_REGS-1:0]  request;
        logic [NUM_CTX-1:0]                 enable;
        logic [CTL_W-1:0]                   rdata;
        logic                               cop0;
        logic                               fault;
        logic                               done;
    } vrp_state_type;

    vrp_state_type st_reg;
    vrp_state_type st_next;

    generate
        if (NUM_CTX < 2 || NUM_PHYS < 2 || ARCH_REGS > CTL_W) begin : g_bad
            $error("vrp_partition_map: unsupported context or pool size");
        end
    endgenerate

    // mapping lookup; software never sees the physical index
    function automatic logic [PW:0] find_map(vrp_state_type s,
                                             logic [CW-1:0] c,
                                             logic [IDX_W-1:0] a);
        logic [PW:0] r;
        r = '0;
        for (int p = 0; p < NUM_PHYS; p++) begin
            if (s.used[p] && s.owner[p] == c && s.arch[p] == a) begin
                r = {1'b1, PW'(p)};
            end
        end
        return r;
    endfunction : find_map

    // lowest free physical register, hit bit on top
    function automatic logic [PW:0] find_free(vrp_state_type s);
        logic [PW:0] r;
        r = '0;
        for (int p = NUM_PHYS - 1; p >= 0; p--) begin
            if (!s.used[p]) begin
                r = {1'b1, PW'(p)};
            end
        end
        return r;
    endfunction : find_free

    logic [PW:0]          ctl_map;
    logic [PW:0]          free_slot;
    logic [PW:0]          dst_map;
    logic [PW:0]          src_map;
    logic [ARCH_REGS-1:0] ins_need;
    logic [ARCH_REGS-1:0] ins_bad;
    logic                 ins_ok;
    logic                 ctl_ok;

    // lookups: control index, free slot, instruction destination and source
    assign ctl_map   = find_map(st_reg, ctl_ctx_in, ctl_wdata_in[IDX_W-1:0]);
    assign free_slot = find_free(st_reg);
    assign dst_map   = find_map(st_reg, ins_ctx_in, ins_dst_in);
    assign src_map   = find_map(st_reg, ins_ctx_in, ins_src_in);
    assign ctl_ok    = ctl_priv_in;

    // every register touched by the instruction is checked
    assign ins_need = ins_use_mask_in
                    | (ARCH_REGS'(1) << ins_src_in)
                    | (ins_write_in ? (ARCH_REGS'(1) << ins_dst_in) : '0);
    assign ins_bad  = ins_need & (st_reg.save[ins_ctx_in]
                    | ~st_reg.access[ins_ctx_in]);
    assign ins_ok   = ins_valid_in && (ins_bad == '0);

    // control side first, instruction side last so hardware sets win
    always_comb begin
        st_next       = st_reg;
        st_next.rdata = '0;
        st_next.cop0  = 1'b0;
        st_next.fault = 1'b0;
        st_next.done  = 1'b0;
        if ((ctl_write_in || ctl_read_in) && !ctl_ok) begin
            st_next.cop0 = 1'b1;
        end else if (ctl_write_in) begin
            case (ctl_sel_in)
                CSEL_ENABLE: begin
                    st_next.enable[ctl_ctx_in] = ctl_wdata_in[ENABLE_BIT];
                end
                CSEL_SAVE: begin
                    st_next.save[ctl_ctx_in] =
                        ctl_wdata_in[ARCH_REGS-1:0];
                end
                CSEL_MODIFY: begin
                    st_next.modify[ctl_ctx_in] =
                        ctl_wdata_in[ARCH_REGS-1:0];
                end
                CSEL_REQUEST: begin
                    st_next.request[ctl_ctx_in] = ctl_wdata_in[ARCH_REGS-1:0];
                end
                CSEL_MAP: begin
                    // an index already mapped keeps its register
                    if (!ctl_map[PW] && free_slot[PW]) begin
                        st_next.used[free_slot[PW-1:0]]  = 1'b1;
                        st_next.owner[free_slot[PW-1:0]] = ctl_ctx_in;
                        st_next.arch[free_slot[PW-1:0]]  =
                            ctl_wdata_in[IDX_W-1:0];
                    end
                    if (ctl_map[PW] || free_slot[PW]) begin
                        st_next.access[ctl_ctx_in]
                            [ctl_wdata_in[IDX_W-1:0]] = 1'b1;
                    end
                end
                CSEL_UNMAP: begin
                    // relies on software having stored the register first
                    if (ctl_map[PW]) begin
                        st_next.used[ctl_map[PW-1:0]] = 1'b0;
                        st_next.access[ctl_ctx_in]
                            [ctl_wdata_in[IDX_W-1:0]] = 1'b0;
                    end
                end
                default: begin
                    // access mask is hardware owned; select zero is empty
                end
            endcase
        end else if (ctl_read_in) begin
            // upper word bits are reserved and read zero
            case (ctl_sel_in)
                CSEL_ENABLE:  st_next.rdata[ENABLE_BIT] =
                                  st_reg.enable[ctl_ctx_in];
                CSEL_ACCESS:  st_next.rdata =
                                  CTL_W'(st_reg.access[ctl_ctx_in]);
                CSEL_SAVE:    st_next.rdata = CTL_W'(st_reg.save[ctl_ctx_in]);
                CSEL_MODIFY:  st_next.rdata =
                                  CTL_W'(st_reg.modify[ctl_ctx_in]);
                CSEL_REQUEST: st_next.rdata =
                                  CTL_W'(st_reg.request[ctl_ctx_in]);
                default:      st_next.rdata = '0;
            endcase
        end
        if (ins_valid_in && !ins_ok) begin
            st_next.request[ins_ctx_in] =
                st_next.request[ins_ctx_in] | ins_bad;
            st_next.fault = 1'b1;
        end else if (ins_ok) begin
            st_next.done = 1'b1;
            if (ins_write_in) begin
                st_next.modify[ins_ctx_in][ins_dst_in] = 1'b1;
            end
        end
    end

    // all masks and the enable bit clear on reset
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // physical data; a faulted instruction never writes
    vrp_phys_pool #(
        .DEPTH (NUM_PHYS),
        .WIDTH (VWIDTH)
    ) u_pool (
        .clock_in    (clock_in),
        .rstn_in     (rstn_in),
        .wr_en_in    (ins_ok && ins_write_in),
        .wr_idx_in   (dst_map[PW-1:0]),
        .wr_data_in  (ins_wdata_in),
        .rd_en_in    (ins_ok),
        .rd_idx_in   (src_map[PW-1:0]),
        .rd_data_out (ins_rdata_out)
    );

    assign ctl_rdata_out          = st_reg.rdata;
    assign ctl_cop0_unusable_out  = st_reg.cop0;
    assign ins_done_out           = st_reg.done;
    assign ins_fault_out          = st_reg.fault;
    assign vector_unit_enable_out = st_reg.enable;

    // checks on the mapping and fault behaviour
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    sequence s_map_new;
        ctl_write_in && ctl_priv_in && ctl_sel_in == CSEL_MAP
            && !ctl_map[PW];
    endsequence
    sequence s_unmap;
        ctl_write_in && ctl_priv_in && ctl_sel_in == CSEL_UNMAP;
    endsequence
    sequence s_bad_ins;
        ins_valid_in && ins_bad != '0;
    endsequence

    map_alloc_a:
        assert property (s_map_new ##0 free_slot[PW] |=>
            st_reg.access[$past(ctl_ctx_in)][$past(ctl_wdata_in[IDX_W-1:0])]
            && $countones(st_reg.used) == $countones($past(st_reg.used)) + 1)
        else $error("map write did not grant a register");
    map_full_a:
        assert property (s_map_new ##0 !free_slot[PW] |=>
            $stable(st_reg.access) && $stable(st_reg.used))
        else $error("access mask changed with an empty pool");
    unmap_free_a:
        assert property (s_unmap ##0 ctl_map[PW] |=>
            !st_reg.used[$past(ctl_map[PW-1:0])] && !st_reg.access
            [$past(ctl_ctx_in)][$past(ctl_wdata_in[IDX_W-1:0])])
        else $error("unmap did not release the register");
    release_noop_a:
        assert property (s_unmap ##0 !ctl_map[PW] |=>
            $stable(st_reg.used) && $stable(st_reg.access))
        else $error("unmap of unmapped index changed state");
    request_set_a:
        assert property (s_bad_ins |=> (st_reg.request[$past(ins_ctx_in)]
            & $past(ins_bad)) == $past(ins_bad))
        else $error("request bits missing after fault");
    fault_raise_a:
        assert property (s_bad_ins |=> ins_fault_out && !ins_done_out)
        else $error("fault not raised or instruction completed");
    modify_set_a:
        assert property (ins_ok && ins_write_in |=> ins_done_out ##0
            st_reg.modify[$past(ins_ctx_in)][$past(ins_dst_in)])
        else $error("modify bit not set on register write");
    reset_zero_a:
        assert property ($rose(rstn_in) |-> st_reg.access == '0
            && st_reg.save == '0 && st_reg.modify == '0
            && st_reg.request == '0 && st_reg.enable == '0)
        else $error("masks not zero after reset");
    unpriv_trap_a:
        assert property ((ctl_write_in || ctl_read_in) && !ctl_priv_in
            |=> ctl_cop0_unusable_out && ctl_rdata_out == '0
            && $stable(st_reg.save) && $stable(st_reg.used))
        else $error("unprivileged control access not trapped");
endmodule : vrp_partition_map

// ===== tb/vrp_os_model.sv
// software and pipeline model driving the partition map request ports
module vrp_os_model
    import vrp_pkg::*;
#(
    parameter int CW = 2
) (
    // clock
    input  wire logic                 clock_in,
    // control register requests
    output logic                      ctl_write_out,
    output logic                      ctl_read_out,
    output logic                      ctl_priv_out,
    output logic      [CW-1:0]        ctl_ctx_out,
    output logic      [CSEL_W-1:0]    ctl_sel_out,
    output logic      [CTL_W-1:0]     ctl_wdata_out,
    // instruction requests
    output logic                      ins_valid_out,
    output logic      [CW-1:0]        ins_ctx_out,
    output logic      [ARCH_REGS-1:0] ins_use_out,
    output logic                      ins_write_out,
    output logic      [IDX_W-1:0]     ins_dst_out,
    output logic      [VWIDTH-1:0]    ins_wdata_out,
    output logic      [IDX_W-1:0]     ins_src_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle at time zero, nothing requested
    initial begin
        {ctl_write_out, ctl_read_out, ctl_priv_out} = 3'h0;
        {ctl_ctx_out, ctl_sel_out, ctl_wdata_out} = '0;
        {ins_valid_out, ins_ctx_out, ins_use_out, ins_write_out} = '0;
        {ins_dst_out, ins_wdata_out, ins_src_out} = '0;
    end

    // one control access, held across exactly one rising edge
    task automatic ctl_op(input logic wr, input logic priv,
                          input logic [CW-1:0] ctx, input logic [2:0] sel,
                          input logic [31:0] wd);
        @(negedge clock_in);
        ctl_write_out <= wr;
        ctl_read_out  <= !wr;
        ctl_priv_out  <= priv;
        ctl_ctx_out   <= ctx;
        ctl_sel_out   <= sel;
        // index registers take five bits, the rest written zero
        ctl_wdata_out <= (sel >= CSEL_MAP) ? {27'h0, wd[4:0]} : wd;
        @(negedge clock_in);
        ctl_write_out <= 1'b0;
        ctl_read_out  <= 1'b0;
        // stale data must not look like a live value
        ctl_wdata_out <= ~ctl_wdata_out;
    endtask : ctl_op

    // one instruction presented for a single cycle
    task automatic ins_op(input logic [CW-1:0] ctx, input logic [31:0] use_m,
                          input logic wr, input logic [4:0] dst,
                          input logic [127:0] wd, input logic [4:0] src);
        @(negedge clock_in);
        ins_valid_out <= 1'b1;
        ins_ctx_out   <= ctx;
        ins_use_out   <= use_m;
        ins_write_out <= wr;
        ins_dst_out   <= dst;
        ins_wdata_out <= wd;
        ins_src_out   <= src;
        @(negedge clock_in);
        ins_valid_out <= 1'b0;
        ins_wdata_out <= ~ins_wdata_out;
    endtask : ins_op
endmodule : vrp_os_model

// ===== tb/tb_top.sv
// self-checking bench for the vector register partition map
module tb_top
    import vrp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // bench nets
    logic               clock_in, rstn_in;
    logic               c_wr, c_rd, c_priv, cop0, i_valid, i_wr, done, fault;
    logic [1:0]         c_ctx, i_ctx;
    logic [2:0]         c_sel;
    logic [31:0]        c_wd, rdata, i_use;
    logic [4:0]         i_dst, i_src;
    logic [127:0]       i_wd, i_rdata, d;
    logic [3:0]         enable;
    logic [31:0]        seed;
    int                 err_total, checked;

    vrp_os_model #(.CW(2)) os (.clock_in(clock_in),
        .ctl_write_out(c_wr), .ctl_read_out(c_rd), .ctl_priv_out(c_priv),
        .ctl_ctx_out(c_ctx), .ctl_sel_out(c_sel), .ctl_wdata_out(c_wd),
        .ins_valid_out(i_valid), .ins_ctx_out(i_ctx), .ins_use_out(i_use),
        .ins_write_out(i_wr), .ins_dst_out(i_dst), .ins_wdata_out(i_wd),
        .ins_src_out(i_src));

    // small pool so exhaustion is reached quickly
    vrp_partition_map #(.NUM_CTX(4), .NUM_PHYS(4)) DUT (
        .clock_in(clock_in), .rstn_in(rstn_in), .ctl_write_in(c_wr),
        .ctl_read_in(c_rd), .ctl_priv_in(c_priv), .ctl_ctx_in(c_ctx),
        .ctl_sel_in(c_sel), .ctl_wdata_in(c_wd), .ctl_rdata_out(rdata),
        .ctl_cop0_unusable_out(cop0), .ins_valid_in(i_valid),
        .ins_ctx_in(i_ctx), .ins_use_mask_in(i_use), .ins_write_in(i_wr),
        .ins_dst_in(i_dst), .ins_wdata_in(i_wd), .ins_src_in(i_src),
        .ins_done_out(done), .ins_fault_out(fault), .ins_rdata_out(i_rdata),
        .vector_unit_enable_out(enable));

    // 100 ns clock
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        lfsr_next = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction : lfsr_next

    task automatic check(input string name, input logic [127:0] seen,
                         input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic close_out;
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    task automatic wr(input logic [1:0] ctx, input logic [2:0] sel,
                      input logic [31:0] wd);
        os.ctl_op(1'b1, 1'b1, ctx, sel, wd);
    endtask : wr

    task automatic rd(input logic [1:0] ctx, input logic [2:0] sel,
                      input logic [31:0] exp, input string name);
        os.ctl_op(1'b0, 1'b1, ctx, sel, 32'h0);
        check(name, rdata, exp);
    endtask : rd

    // instruction with exactly one of done or fault expected
    task automatic ins(input logic [1:0] ctx, input logic [31:0] m,
                       input logic w, input logic [4:0] dst, src,
                       input logic f);
        os.ins_op(ctx, m, w, dst, d, src);
        check("done", done, !f);
        check("fault", fault, f);
    endtask : ins

    // a hang is cut short as a mismatch
    initial begin
        repeat (20000) @(posedge clock_in);
        err_total++;
        close_out;
    end

    initial begin
        seed = 32'hEBBA;
        d = '0;
        rstn_in = 1'b0;
        repeat (8) @(posedge clock_in);
        @(negedge clock_in);
        rstn_in = 1'b1;
        for (int c = 0; c < 4; c++) begin
            for (int s = 1; s < 6; s++) begin
                rd(c[1:0], s[2:0], 32'h0, "reset mask");
            end
        end
        check("enable out", enable, 4'h0);
        // grant W1 then W2 to context 0
        wr(2'h0, CSEL_MAP, 32'h1);
        rd(2'h0, CSEL_ACCESS, 32'h2, "access W1");
        wr(2'h0, CSEL_MAP, 32'h2);
        rd(2'h0, CSEL_ACCESS, 32'h6, "access W2");
        // random data written then read back through the hidden mapping
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 4; k++) begin
                seed = lfsr_next(seed);
                d[k*32+:32] = seed;
            end
            ins(2'h0, 32'h0, 1'b1, 5'(1 + i % 2), 5'(1 + i % 2), 1'b0);
            ins(2'h0, 32'h0, 1'b0, 5'h0, 5'(1 + i % 2), 1'b0);
            check("read back", i_rdata, d);
        end
        rd(2'h0, CSEL_MODIFY, 32'h6, "modify set");
        // switch threads: save holds access or incoming saved registers
        wr(2'h0, CSEL_SAVE, 32'h6);
        rd(2'h0, CSEL_SAVE, 32'h6, "save mask");
        wr(2'h0, CSEL_MODIFY, 32'h0);
        ins(2'h0, 32'h6, 1'b1, 5'h2, 5'h1, 1'b1);
        check("rdata held", i_rdata, d);
        rd(2'h0, CSEL_REQUEST, 32'h6, "request");
        rd(2'h0, CSEL_MODIFY, 32'h0, "no modify");
        // registers stored, save cleared, W1 restored by a load
        wr(2'h0, CSEL_SAVE, 32'h0);
        ins(2'h0, 32'h6, 1'b1, 5'h1, 5'h2, 1'b0);
        rd(2'h0, CSEL_MODIFY, 32'h2, "restore sets");
        wr(2'h0, CSEL_MODIFY, 32'h0);
        rd(2'h0, CSEL_MODIFY, 32'h0, "modify clear");
        // random use masks on a context owning nothing, src W0 folded in
        for (int i = 0; i < 3; i++) begin
            seed = lfsr_next(seed);
            wr(2'h1, CSEL_REQUEST, 32'h0);
            ins(2'h1, seed, 1'b0, 5'h0, 5'h0, 1'b1);
            rd(2'h1, CSEL_REQUEST, seed | 32'h1, "random request");
        end
        // exhaust the pool of four, then move one register across contexts
        wr(2'h2, CSEL_MAP, 32'h0);
        wr(2'h2, CSEL_MAP, 32'h1);
        wr(2'h2, CSEL_MAP, 32'h2);
        rd(2'h2, CSEL_ACCESS, 32'h3, "pool empty");
        wr(2'h2, CSEL_UNMAP, 32'h5);
        rd(2'h2, CSEL_ACCESS, 32'h3, "unmap unmapped");
        wr(2'h3, CSEL_MAP, 32'h9);
        rd(2'h3, CSEL_ACCESS, 32'h0, "still empty");
        wr(2'h2, CSEL_UNMAP, 32'h1);
        rd(2'h2, CSEL_ACCESS, 32'h1, "unmapped");
        wr(2'h3, CSEL_MAP, 32'h9);
        rd(2'h3, CSEL_ACCESS, 32'h200, "remapped");
        // access mask is hardware owned, a software write is ignored
        wr(2'h3, CSEL_ACCESS, 32'hFFFF_FFFF);
        rd(2'h3, CSEL_ACCESS, 32'h200, "access kept");
        // unprivileged accesses trap and change nothing
        os.ctl_op(1'b1, 1'b0, 2'h0, CSEL_SAVE, 32'hF);
        check("trap write", cop0, 1'b1);
        os.ctl_op(1'b0, 1'b0, 2'h3, CSEL_ACCESS, 32'h0);
        check("trap read", {cop0, rdata}, {1'b1, 32'h0});
        rd(2'h0, CSEL_SAVE, 32'h0, "save kept");
        // enable bit alone is stored, index registers read zero
        wr(2'h1, CSEL_ENABLE, 32'h1);
        rd(2'h1, CSEL_ENABLE, 32'h1, "enable");
        check("enable out", enable, 4'h2);
        rd(2'h1, CSEL_MAP, 32'h0, "map reads zero");
        close_out;
    end
endmodule : tb_top
